// ---- dbgp_cfg.svh ----
// constants for the debug serial and trace port
// assumes: included by bare name from package and design files
`ifndef DBGP_CFG_SVH
`define DBGP_CFG_SVH

`define DBGP_CLK_PERIOD_NS 5
`define DBGP_TRACE_DIV     2
`define DBGP_RESP_BITS     17
`define DBGP_FIFO_DEPTH    8
`define DBGP_NIB_W         4
`define DBGP_CODE_IDLE     4'h0
`define DBGP_CODE_START_C  4'hC
`define DBGP_CODE_START_D  4'hD
`define DBGP_CODE_HALT     4'hF

`endif

// ---- dbgp_pkg.sv ----
// types shared by the debug serial and trace port
// assumes: dbgp_cfg.svh in the include path
`include "dbgp_cfg.svh"

package dbgp_pkg;

   typedef logic [`DBGP_NIB_W-1:0] dbgp_nib_t;

   // gray along idle -> run -> quiet
   typedef enum logic [1:0] {
      DBGP_TR_IDLE  = 2'h0,
      DBGP_TR_RUN   = 2'h1,
      DBGP_TR_QUIET = 2'h3
   } dbgp_trace_state_t;

endpackage

// ---- dbgp_stream_if.sv ----
// valid/ready word stream between the port logic and its fifo
// assumes: both ends share one clock
`timescale 1ns/1ps
`default_nettype none

interface dbgp_stream_if #(
   parameter int W = 4
);
   logic [W-1:0] data;
   logic         valid;
   logic         ready;

   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface

`default_nettype wire

// ---- dbgp_fifo.sv ----
// flip-flop fifo with valid/ready at both sides
// assumes: one clock, asynchronous active-low reset, depth a power of two
`timescale 1ns/1ps
`default_nettype none

module dbgp_fifo #(
   parameter int W     = 4,
   parameter int DEPTH = 8
) (
   input  wire logic   clk,
   input  wire logic   nrst,
   dbgp_stream_if.snk  wr,
   dbgp_stream_if.src  rd
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0]  mem_r [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0]   cnt_r;
   wire           full;
   wire           empty;
   wire           push;
   wire           pop;

   assign full     = (cnt_r == (AW+1)'(DEPTH));
   assign empty    = (cnt_r == '0);
   assign wr.ready = !full;
   assign rd.valid = !empty;
   assign rd.data  = mem_r[rp_r];
   assign push     = wr.valid && !full;
   assign pop      = rd.ready && !empty;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wp_r] <= wr.data;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         wp_r  <= push ? wp_r + 1'b1 : wp_r;
         rp_r  <= pop ? rp_r + 1'b1 : rp_r;
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

endmodule

`default_nettype wire

// ---- dbgp_port.sv ----
// debug serial link and real-time trace outputs
// assumes: core status and capture stream in the clk domain; serial clock, serial
// input and halt request are asynchronous pins
`timescale 1ns/1ps
`default_nettype none
`include "dbgp_cfg.svh"

// How it works
// - serial input is synchronized and taken only once serial clock is validated high
// - serial output is a register, updated one cycle after validated clock high
// - response word leaves bit by bit through the serial output
// - captured data and breakpoint status appear at the four-bit capture bus
// - sampling clock rises in the middle of each status and capture window
// - quiet bit freezes sampling clock, status and capture outputs and all-ones flag
// - clearing the quiet bit resumes normal toggling of trace outputs
// - sampling clock idles until status first shows C, D or F
// - status code follows core state in step with the processor clock, not bus transfers
// - all-ones flag is the AND of the four status bits
// - serial clock level is valid when equal at two consecutive clock edges
// - at validated serial clock rise, input sampled; output changes one clock cycle later
// - manual halt shows 0xF in status code and capture bus
module dbgp_port #(
   parameter int TRACE_DIV  = `DBGP_TRACE_DIV,
   parameter int RESP_BITS  = `DBGP_RESP_BITS,
   parameter int FIFO_DEPTH = `DBGP_FIFO_DEPTH
) (
   input  wire logic                  clk,
   input  wire logic                  nrst,
   input  wire logic                  debug_serial_clock,
   input  wire logic                  debug_serial_in,
   output var  logic                  debug_serial_out,
   input  wire logic                  manual_halt_request,
   input  wire logic                  trace_quiet_bit,
   input  wire logic [3:0]            core_status_in,
   input  wire logic                  core_resume,
   output var  logic                  core_halt_req,
   input  wire logic [3:0]            capture_data,
   input  wire logic                  capture_valid,
   output var  logic                  capture_ready,
   input  wire logic [RESP_BITS-1:0]  resp_word,
   input  wire logic                  resp_load,
   output var  logic [RESP_BITS-1:0]  cmd_word,
   output var  logic                  cmd_word_valid,
   output var  logic [3:0]            core_status_code,
   output var  logic [3:0]            debug_capture_bus,
   output var  logic                  status_all_ones_flag,
   output var  logic                  status_sampling_clock
);
   localparam int PW = (TRACE_DIV > 1) ? $clog2(TRACE_DIV) : 1;
   localparam int CW = $clog2(RESP_BITS + 1);
   localparam logic [PW-1:0] PH_LAST = PW'(TRACE_DIV - 1);
   localparam logic [PW-1:0] PH_MID  = PW'(TRACE_DIV / 2);
   localparam logic [CW-1:0] CNT_LAST = CW'(RESP_BITS - 1);

   function automatic logic is_start_code(input dbgp_pkg::dbgp_nib_t c);
      is_start_code = (c == `DBGP_CODE_START_C) || (c == `DBGP_CODE_START_D)
                    || (c == `DBGP_CODE_HALT);
   endfunction

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic sclk_s1_r;
   logic sclk_s2_r;
   logic sclk_s3_r;
   logic din_s1_r;
   logic din_s2_r;
   logic din_s3_r;
   logic halt_s1_r;
   logic halt_s2_r;
   logic halt_s3_r;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         {sclk_s1_r, sclk_s2_r, sclk_s3_r} <= 3'h0;
         {din_s1_r, din_s2_r, din_s3_r}    <= 3'h0;
         {halt_s1_r, halt_s2_r, halt_s3_r} <= 3'h0;
      end else begin
         {sclk_s1_r, sclk_s2_r, sclk_s3_r} <= {debug_serial_clock, sclk_s1_r, sclk_s2_r};
         {din_s1_r, din_s2_r, din_s3_r}    <= {debug_serial_in, din_s1_r, din_s2_r};
         {halt_s1_r, halt_s2_r, halt_s3_r} <= {manual_halt_request, halt_s1_r, halt_s2_r};
      end
   end

   // ----------------------------------------------------------------
   // serial clock validation and shift engine
   // ----------------------------------------------------------------
   logic                 lvl_r;
   logic                 lvl_q_r;
   logic                 tx_go_r;
   logic [RESP_BITS-1:0] tx_sh_r;
   logic [RESP_BITS-1:0] rx_sh_r;
   logic [CW-1:0]        rx_cnt_r;
   wire                  lvl_nxt;
   wire                  sclk_rise;
   wire                  rx_last;

   assign lvl_nxt   = (sclk_s2_r == sclk_s3_r) ? sclk_s3_r : lvl_r;
   assign sclk_rise = lvl_r && !lvl_q_r;
   assign rx_last   = (rx_cnt_r == CNT_LAST);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lvl_r   <= 1'b0;
         lvl_q_r <= 1'b0;
         tx_go_r <= 1'b0;
      end else begin
         lvl_r   <= lvl_nxt;
         lvl_q_r <= lvl_r;
         tx_go_r <= sclk_rise;
      end
   end

   // receive: bit taken only at validated rise
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rx_sh_r        <= '0;
         rx_cnt_r       <= '0;
         cmd_word       <= '0;
         cmd_word_valid <= 1'b0;
      end else begin
         cmd_word_valid <= sclk_rise && rx_last;
         if (sclk_rise) begin
            rx_sh_r  <= {rx_sh_r[RESP_BITS-2:0], din_s3_r};
            rx_cnt_r <= rx_last ? '0 : rx_cnt_r + 1'b1;
            if (rx_last) begin
               cmd_word <= {rx_sh_r[RESP_BITS-2:0], din_s3_r};
            end
         end
      end
   end

   // transmit: msb first, one bit per validated rise, held otherwise
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tx_sh_r          <= '0;
         debug_serial_out <= 1'b0;
      end else begin
         if (resp_load) begin
            tx_sh_r <= resp_word;
         end else if (tx_go_r) begin
            tx_sh_r <= {tx_sh_r[RESP_BITS-2:0], 1'b0};
         end
         if (tx_go_r) begin
            debug_serial_out <= tx_sh_r[RESP_BITS-1];
         end
      end
   end

   // ----------------------------------------------------------------
   // halt request
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         core_halt_req <= 1'b0;
      end else if (halt_s2_r && !halt_s3_r) begin
         core_halt_req <= 1'b1;
      end else if (core_resume) begin
         core_halt_req <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // capture fifo
   // ----------------------------------------------------------------
   dbgp_stream_if #(.W(4)) cap_in ();
   dbgp_stream_if #(.W(4)) cap_out ();

   assign cap_in.data   = capture_data;
   assign cap_in.valid  = capture_valid;
   assign capture_ready = cap_in.ready;

   dbgp_fifo #(
      .W     (4),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk  (clk),
      .nrst (nrst),
      .wr   (cap_in),
      .rd   (cap_out)
   );

   // ----------------------------------------------------------------
   // trace window divider and state
   // ----------------------------------------------------------------
   dbgp_pkg::dbgp_trace_state_t st_r;
   dbgp_pkg::dbgp_trace_state_t st_nxt;
   logic [PW-1:0]               ph_r;
   wire                         tr_en;
   wire                         running;
   wire                         start_seen;
   wire [3:0]                   status_nxt;
   wire [3:0]                   capture_nxt;

   assign tr_en         = (ph_r == '0);
   assign running       = (st_r == dbgp_pkg::DBGP_TR_RUN);
   assign start_seen    = is_start_code(core_status_in);
   // halt code wins over both live status and captured data
   assign status_nxt    = core_halt_req ? `DBGP_CODE_HALT : core_status_in;
   assign capture_nxt   = core_halt_req ? `DBGP_CODE_HALT
                        : (cap_out.valid ? cap_out.data : `DBGP_CODE_IDLE);
   // frozen fifo stalls the source while quiet
   // pop exactly when a window is loaded without a halt request, so a resumed or first window shows no repeat
   assign cap_out.ready = tr_en && (st_nxt == dbgp_pkg::DBGP_TR_RUN) && !core_halt_req;

   always_comb begin
      case (st_r)
         dbgp_pkg::DBGP_TR_IDLE: begin
            st_nxt = (tr_en && start_seen) ? dbgp_pkg::DBGP_TR_RUN : st_r;
         end
         dbgp_pkg::DBGP_TR_RUN: begin
            st_nxt = (tr_en && trace_quiet_bit) ? dbgp_pkg::DBGP_TR_QUIET : st_r;
         end
         dbgp_pkg::DBGP_TR_QUIET: begin
            st_nxt = (tr_en && !trace_quiet_bit) ? dbgp_pkg::DBGP_TR_RUN : st_r;
         end
         default: begin
            st_nxt = dbgp_pkg::DBGP_TR_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ph_r <= '0;
         st_r <= dbgp_pkg::DBGP_TR_IDLE;
      end else begin
         ph_r <= (ph_r == PH_LAST) ? '0 : ph_r + 1'b1;
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // trace outputs
   // ----------------------------------------------------------------
   wire load_win;

   assign load_win = tr_en && (st_nxt == dbgp_pkg::DBGP_TR_RUN);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         core_status_code      <= `DBGP_CODE_IDLE;
         debug_capture_bus     <= `DBGP_CODE_IDLE;
         status_all_ones_flag  <= 1'b0;
         status_sampling_clock <= 1'b0;
      end else if (load_win) begin
         core_status_code      <= status_nxt;
         debug_capture_bus     <= capture_nxt;
         status_all_ones_flag  <= &status_nxt;
         status_sampling_clock <= 1'b0;
      end else if (running && ph_r == PH_MID) begin
         status_sampling_clock <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence s_window_open;
      tr_en && running && (st_nxt == dbgp_pkg::DBGP_TR_RUN);
   endsequence

   sequence s_clock_centre;
      !status_sampling_clock ##1 status_sampling_clock;
   endsequence

   a_flag_and: assert property (
      status_all_ones_flag == &core_status_code)
      else $error("all-ones flag differs from status AND");

   a_sclk_centred: assert property (
      s_window_open |=> s_clock_centre)
      else $error("sampling clock edge not centred in window");

   a_quiet_frozen: assert property (
      (st_r == dbgp_pkg::DBGP_TR_QUIET) && $past(st_r == dbgp_pkg::DBGP_TR_QUIET)
      |-> $stable(core_status_code) && $stable(debug_capture_bus)
          && $stable(status_sampling_clock))
      else $error("trace outputs moved while quiet");

   a_resume_toggle: assert property (
      (st_r == dbgp_pkg::DBGP_TR_QUIET) && !trace_quiet_bit
      |-> ##[1:4] $rose(status_sampling_clock))
      else $error("sampling clock did not resume");

   a_idle_clock: assert property (
      (st_r == dbgp_pkg::DBGP_TR_IDLE) |-> !status_sampling_clock)
      else $error("sampling clock ran before start code");

   a_start_code: assert property (
      (st_r == dbgp_pkg::DBGP_TR_IDLE) ##1 (st_r == dbgp_pkg::DBGP_TR_RUN)
      |-> is_start_code($past(core_status_in)))
      else $error("trace started by a wrong status code");

   a_halt_code: assert property (
      s_window_open ##0 core_halt_req
      |=> (core_status_code == `DBGP_CODE_HALT) && (debug_capture_bus == `DBGP_CODE_HALT))
      else $error("halt not shown as all ones");

   a_status_follow: assert property (
      s_window_open ##0 !core_halt_req |=> core_status_code == $past(core_status_in))
      else $error("status code not taken from core state");

   a_level_valid: assert property (
      $rose(lvl_r) |-> $past(sclk_s2_r) && $past(sclk_s3_r))
      else $error("serial clock level accepted from one sample");

   a_rx_gated: assert property (
      $changed(rx_cnt_r) |-> $past(lvl_r) && !$past(lvl_q_r, 1))
      else $error("serial input taken without validated rise");

   a_dso_update: assert property (
      sclk_rise |=> tx_go_r ##1 (debug_serial_out == $past(tx_sh_r[RESP_BITS-1])))
      else $error("serial output not updated after validated rise");

   a_dso_hold: assert property (
      !tx_go_r |=> $stable(debug_serial_out))
      else $error("serial output changed between clock edges");

endmodule

`default_nettype wire

// ---- dbgp_probe.sv ----
// probe model: drives the debug serial link one frame at a time
// assumes: serial clock idles low between frames, frames sent from one process
`timescale 1ns/1ps
`default_nettype none

module dbgp_probe #(
   parameter int NB   = 17,
   parameter int HALF = 32
) (
   output var  logic sclk,
   output var  logic sdin,
   input  wire logic sdout
);
   initial begin
      sclk = 1'h0;
      sdin = 1'h0;
   end

   // shorter than a clk period: straddles one edge at most, so it is no bit
   task automatic glitch();
      sclk = 1'h1;
      #4.5;
      sclk = 1'h0;
      #20;
   endtask

   // high and low 32 ns each: slower than a fifth of the trace clock
   task automatic frame(input logic [NB-1:0] tx, output logic [NB-1:0] rx);
      for (int i = NB - 1; i >= 0; i--) begin
         sdin = tx[i];
         #(HALF);
         if (i < NB - 1) rx[i+1] = sdout;
         sclk = 1'h1;
         #(HALF);
         sclk = 1'h0;
      end
      #(2 * HALF);
      rx[0] = sdout;
      // released line: keep no stale level
      sdin  = ~sdin;
   endtask
endmodule

`default_nettype wire

// ---- dbgp_port_tb_top.sv ----
// self-checking bench for the debug serial and trace port
// assumes: dbgp_cfg.svh in the include path, probe model compiled first
`timescale 1ns/1ps
`default_nettype none
`include "dbgp_cfg.svh"

module dbgp_port_tb_top;
   localparam int NB = `DBGP_RESP_BITS;
   logic          clk = 1'h0;
   logic          nrst = 1'h0;
   logic          sclk, sdin, sdout;
   logic          halt_pin = 1'h0, quiet = 1'h0, resume = 1'h0, halt_req;
   logic [3:0]    status_in = 4'h0, cap_data = 4'h0, code, bus;
   logic          cap_valid = 1'h0, cap_ready, flag, sclk_out;
   logic [NB-1:0] resp = '0, cmd, got_cmd;
   logic          resp_load = 1'h0, cmd_valid;
   int            mismatches = 0, num_checks = 0, cycles = 0, n_rise = 0, n_cmd = 0;
   logic          collect = 1'h0;
   logic [3:0]    cap_q[$];

   always #2.5 clk = ~clk;

   dbgp_probe #(.NB(NB)) i_dbgp_probe (.sclk(sclk), .sdin(sdin), .sdout(sdout));

   dbgp_port i_dbgp_port (
      .clk(clk), .nrst(nrst), .debug_serial_clock(sclk), .debug_serial_in(sdin),
      .debug_serial_out(sdout), .manual_halt_request(halt_pin),
      .trace_quiet_bit(quiet), .core_status_in(status_in), .core_resume(resume),
      .core_halt_req(halt_req), .capture_data(cap_data), .capture_valid(cap_valid),
      .capture_ready(cap_ready), .resp_word(resp), .resp_load(resp_load),
      .cmd_word(cmd), .cmd_word_valid(cmd_valid), .core_status_code(code),
      .debug_capture_bus(bus), .status_all_ones_flag(flag),
      .status_sampling_clock(sclk_out)
   );

   // ---------------------------------------------------------------
   // monitors
   // ---------------------------------------------------------------
   always @(posedge sclk_out) begin
      n_rise++;
      if (collect && bus !== 4'h0) cap_q.push_back(bus);
   end

   always @(posedge clk) begin
      if (cmd_valid === 1'h1) begin
         got_cmd = cmd;
         n_cmd++;
      end
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         $display("unexpected at %0t: run did not finish", $time);
         final_report();
      end
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk_v(input logic [NB-1:0] got, input logic [NB-1:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
      end
   endtask

   task automatic chk_b(input logic got, input logic exp, input string m);
      chk_v({{(NB-1){1'h0}}, got}, {{(NB-1){1'h0}}, exp}, m);
   endtask

   task automatic push(input logic [3:0] d);
      int n;
      cap_data  = d;
      cap_valid = 1'h1;
      n = 0;
      @(posedge clk);
      while (cap_ready !== 1'h1 && n < 50) begin
         n++;
         @(posedge clk);
      end
      // valid stays up between pushes; the caller lowers it after the last
      #1;
      if (n == 50) chk_b(1'h0, 1'h1, "push accepted");
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_idle();
      cyc(20);
      chk_v(n_rise, 0, "clock idle before start code");
      chk_b(sclk_out, 1'h0, "clock low while idle");
      status_in = 4'hD;
      cyc(8);
      chk_b(n_rise > 0, 1'h1, "clock starts with D");
      $display("test idle done");
   endtask

   task automatic t_status();
      logic [3:0] codes[5] = '{4'hC, 4'hF, 4'h1, 4'h7, 4'hE};
      foreach (codes[k]) begin
         status_in = codes[k];
         cyc(6);
         chk_v(code, codes[k], "status code");
         chk_b(flag, &codes[k], "all ones flag");
      end
      $display("test status done");
   endtask

   task automatic t_fifo();
      int r0;
      logic [3:0] c0;
      quiet = 1'h1;
      cyc(4);
      r0 = n_rise;
      c0 = code;
      status_in = 4'h5;
      for (int k = 1; k <= 8; k++) push(k[3:0]);
      cap_valid = 1'h0;
      cyc(2);
      chk_b(cap_ready, 1'h0, "fifo full refuses");
      cyc(20);
      chk_v(n_rise, r0, "clock frozen in quiet");
      chk_v(code, c0, "status frozen in quiet");
      // probe resynchronizes: fresh capture after the quiet span
      cap_q.delete();
      collect = 1'h1;
      quiet = 1'h0;
      cyc(40);
      collect = 1'h0;
      chk_v(code, 4'h5, "status resumes");
      chk_v(cap_q.size(), 8, "drained count");
      foreach (cap_q[k]) chk_v(cap_q[k], k + 1, "captured order");
      chk_b(cap_ready, 1'h1, "fifo free again");
      $display("test fifo done");
   endtask

   task automatic t_halt();
      halt_pin = 1'h1;
      cyc(10);
      halt_pin = 1'h0;
      cyc(10);
      chk_b(halt_req, 1'h1, "halt requested");
      chk_v(code, 4'hF, "halt status code");
      chk_v(bus, 4'hF, "halt capture bus");
      chk_b(flag, 1'h1, "halt flag");
      resume = 1'h1;
      cyc(1);
      resume = 1'h0;
      cyc(6);
      chk_b(halt_req, 1'h0, "halt cleared");
      chk_v(code, 4'h5, "status back");
      $display("test halt done");
   endtask

   task automatic t_serial();
      logic [NB-1:0] tx[2] = '{17'h1_2345, 17'h0_AAAA};
      logic [NB-1:0] rs[2] = '{17'h1_5A3C, 17'h0_0001};
      logic [NB-1:0] rx;
      foreach (tx[k]) begin
         resp = rs[k];
         resp_load = 1'h1;
         cyc(1);
         resp_load = 1'h0;
         if (k == 0) i_dbgp_probe.glitch();
         i_dbgp_probe.frame(tx[k], rx);
         cyc(8);
         chk_v(n_cmd, k + 1, "one word per frame");
         chk_v(got_cmd, tx[k], "received word");
         chk_v(rx, rs[k], "returned word");
      end
      $display("test serial done");
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial begin
      cyc(8);
      nrst = 1'h1;
      cyc(2);
      t_idle();
      t_status();
      t_fifo();
      t_halt();
      t_serial();
      final_report();
   end
endmodule

`default_nettype wire
